// file: hdl/sideband_pkg.sv
// sideband_pkg: constants and types shared by the switch side-band logic
// assumes: a single 50 MHz core clock, asynchronous active-low reset
package sideband_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 50;
  localparam int HW_AGE_PERIOD_MS = 1000;
  localparam int HW_AGE_PERIOD_CYC = HW_AGE_PERIOD_MS * CLK_MHZ * 1000;
  localparam int CFG_ACCESS_CYC = 2;
  localparam int CFG_TIMEOUT_CYC = 256;

  // ****************************************************************
  // configuration bus layout
  // ****************************************************************
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int ACC_BIT = 27;
  localparam int WORD_LSB = 2;
  localparam int IDX_W = ACC_BIT - WORD_LSB;

  // word indices of the local registers
  localparam logic [IDX_W-1:0] REG_LDF_WM = 25'h0000000;
  localparam logic [IDX_W-1:0] REG_ADF_WM = 25'h0000001;
  localparam logic [IDX_W-1:0] REG_HDF_WM = 25'h0000002;
  localparam logic [IDX_W-1:0] REG_AGE_CTRL = 25'h0000003;
  localparam logic [IDX_W-1:0] REG_PAUSE_MODE = 25'h0000004;
  localparam logic [IDX_W-1:0] REG_AGE_STAT = 25'h0000005;

  // aging control field positions
  localparam int AGE_SW_EN_BIT = 0;
  localparam int AGE_SW_START_BIT = 1;
  localparam int AGE_HW_EN_BIT = 2;

  // ****************************************************************
  // data fifo watermarks and interrupt vector
  // ****************************************************************
  localparam int NUM_FIFOS = 3;
  localparam int LVL_W = 10;
  localparam int FIFO_DEPTH = 512;
  localparam logic [LVL_W-1:0] WM_RST = 10'h180;
  localparam logic AGE_SW_EN_RST = 1'b0;
  localparam logic AGE_HW_EN_RST = 1'b1;
  localparam int IRQ_W = 32;
  localparam int IRQ_HASH_AGE = 6;
  localparam int IRQ_CAM_AGE = 7;

  // ****************************************************************
  // aging tables, pause and debug
  // ****************************************************************
  localparam int AGE_BUCKETS = 8;
  localparam int HASH_ENTRIES = 16384;
  localparam int BUCKET_ENTRIES = HASH_ENTRIES / AGE_BUCKETS;
  localparam int CAM_ENTRIES = 32;
  localparam int N_PORTS = 11;
  localparam int PRI_N = 8;
  localparam logic [PRI_N-1:0] PAUSE_ALL = 8'hFF;
  localparam logic [PRI_N-1:0] PAUSE_NONE = 8'h00;
  localparam int DBG_SEL_W = 9;
  localparam int DBG_PORTS = 12;
  localparam int DBG_WIDE_PORTS = 2;

  typedef enum {CFG_IDLE, CFG_WAIT, CFG_DONE} cfg_state_t;
  typedef enum {AGE_IDLE, AGE_SCAN} age_state_t;

endpackage : sideband_pkg

// file: hdl/aging_if.sv
// aging_if: control and progress signals between the side-band top and the aging walker
// assumes: both ends clocked by the same core clock
interface aging_if #(
  parameter int HASH_W = 11,
  parameter int CAM_W = 5
);
  logic start;
  logic [HASH_W-1:0] hash_idx;
  logic [CAM_W-1:0] cam_idx;
  logic hash_busy;
  logic cam_busy;
  logic hash_done;
  logic cam_done;

  modport walker (
    input start,
    output hash_idx,
    output cam_idx,
    output hash_busy,
    output cam_busy,
    output hash_done,
    output cam_done
  );

  modport ctrl (
    output start,
    input hash_idx,
    input cam_idx,
    input hash_busy,
    input cam_busy,
    input hash_done,
    input cam_done
  );
endinterface : aging_if

// file: hdl/aging_walker.sv
// aging_walker: walks the hash aging buckets and the collision aging table
// assumes: start is a one-cycle pulse, given only while both walks are idle
module aging_walker
  import sideband_pkg::*;
#(
  parameter int BUCKET_N = BUCKET_ENTRIES,
  parameter int CAM_N = CAM_ENTRIES
)
(
  input wire logic core_clk,
  input wire logic resetn,
  aging_if.walker ag
);

  localparam int HW = $clog2(BUCKET_N);
  localparam int CW = $clog2(CAM_N);
  localparam logic [HW-1:0] HASH_LAST = HW'(BUCKET_N - 1);
  localparam logic [CW-1:0] CAM_LAST = CW'(CAM_N - 1);

  age_state_t hash_state_ff;
  age_state_t cam_state_ff;

  // ****************************************************************
  // hash buckets
  // ****************************************************************
  // all buckets share one offset, so every bucket sees entry n in the same cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hash_state_ff <= AGE_IDLE;
      ag.hash_idx <= '0;
      ag.hash_done <= 1'b0;
    end
    else
    begin
      ag.hash_done <= 1'b0;
      unique case (hash_state_ff)
        AGE_IDLE:
        begin
          if (ag.start)
          begin
            hash_state_ff <= AGE_SCAN;
            ag.hash_idx <= '0;
          end
        end
        AGE_SCAN:
        begin
          if (ag.hash_idx == HASH_LAST)
          begin
            hash_state_ff <= AGE_IDLE;
            ag.hash_done <= 1'b1;
          end
          else
          begin
            ag.hash_idx <= ag.hash_idx + 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // collision table
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cam_state_ff <= AGE_IDLE;
      ag.cam_idx <= '0;
      ag.cam_done <= 1'b0;
    end
    else
    begin
      ag.cam_done <= 1'b0;
      unique case (cam_state_ff)
        AGE_IDLE:
        begin
          if (ag.start)
          begin
            cam_state_ff <= AGE_SCAN;
            ag.cam_idx <= '0;
          end
        end
        AGE_SCAN:
        begin
          if (ag.cam_idx == CAM_LAST)
          begin
            cam_state_ff <= AGE_IDLE;
            ag.cam_done <= 1'b1;
          end
          else
          begin
            ag.cam_idx <= ag.cam_idx + 1'b1;
          end
        end
      endcase
    end
  end

  assign ag.hash_busy = (hash_state_ff == AGE_SCAN);
  assign ag.cam_busy = (cam_state_ff == AGE_SCAN);

endmodule : aging_walker

// file: hdl/switch_sideband.sv
// switch_sideband: configuration slave, interrupt vector, pause and debug read ports
// assumes: all side-band pins are synchronous to core_clk; MACs synchronise themselves
//
// Summary of operation
// - top address bit selects the accumulator
// - byte address, whole words only, low bits dropped
// - register index is the word address
// - internal timeout ends access with error
// - unmapped word address answers with error
// - each interrupt is a one-cycle pulse
// - no mask, no status, pulses driven directly
// - flags 0,2,4 push at or above watermark
// - flags 1,3,5 push while fifo full
// - flag 6 pulses when hash aging ends
// - software aging waits for start latch
// - eight buckets scanned in parallel, first to last
// - collision table walked, then flag 7
// - port mode status is 00 or FF
// - xoff blocks new packets, not ongoing ones
// - one external pause per port, per priority
// - pause vectors eight bits, one means xoff
// - 9-bit select, 32-bit data, both pipelined
// - selects 1 to 12 show egress edge fields
module switch_sideband
  import sideband_pkg::*;
#(
  parameter int AGE_PERIOD_CYC = HW_AGE_PERIOD_CYC,
  parameter int TIMEOUT_CYC = CFG_TIMEOUT_CYC,
  parameter int ACCESS_CYC = CFG_ACCESS_CYC,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int BUCKET_N = BUCKET_ENTRIES,
  parameter int CAM_N = CAM_ENTRIES
)
(
  input wire logic core_clk,
  input wire logic resetn,
  // configuration bus
  input wire logic [ADDR_W-1:0] apb_paddr,
  input wire logic apb_psel,
  input wire logic apb_penable,
  input wire logic apb_pwrite,
  input wire logic [DATA_W-1:0] apb_pwdata,
  output logic apb_pready,
  output logic [DATA_W-1:0] apb_prdata,
  output logic apb_pslverr,
  input wire logic cfg_stall,
  // data fifo push requests and fill levels: learning, aging, hit update
  input wire logic [NUM_FIFOS-1:0] fifo_push,
  input wire logic [NUM_FIFOS-1:0][LVL_W-1:0] fifo_level,
  output logic [IRQ_W-1:0] interrupts,
  // aging walk progress
  output logic [$clog2(BUCKET_N)-1:0] age_hash_idx,
  output logic [$clog2(CAM_N)-1:0] age_cam_idx,
  // pause
  input wire logic [N_PORTS-1:0] rm_port_paused,
  input wire logic [N_PORTS-1:0][PRI_N-1:0] rm_pfc_pause,
  output logic [N_PORTS-1:0][PRI_N-1:0] pfc_status,
  input wire logic [N_PORTS-1:0][PRI_N-1:0] ext_pause,
  input wire logic [N_PORTS-1:0] sched_start_req,
  input wire logic [N_PORTS-1:0][2:0] sched_start_pri,
  output logic [N_PORTS-1:0] sched_start_grant,
  // debug read
  input wire logic [DBG_SEL_W-1:0] debug_read_select,
  input wire logic [DBG_PORTS-1:0][4:0] dbg_tx_valid_bytes,
  input wire logic [DBG_PORTS-1:0] dbg_tx_halt,
  input wire logic [DBG_PORTS-1:0] dbg_tx_last,
  input wire logic [DBG_PORTS-1:0] dbg_tx_first,
  output logic [DATA_W-1:0] debug_read_data
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int PW = $clog2(AGE_PERIOD_CYC + 1);
  localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_CYC - 1);
  localparam logic [TW-1:0] ACCESS_LAST = TW'(ACCESS_CYC - 1);
  localparam logic [PW-1:0] PERIOD_LAST = PW'(AGE_PERIOD_CYC - 1);
  localparam logic [LVL_W:0] FULL_LVL = (LVL_W + 1)'(DEPTH);

  // ****************************************************************
  // configuration slave
  // ****************************************************************
  cfg_state_t cfg_state_ff;
  logic [TW-1:0] wait_cnt_ff;
  logic [TW-1:0] work_cnt_ff;
  logic [DATA_W-1:0] acc_ff;
  logic [NUM_FIFOS-1:0][LVL_W-1:0] wm_ff;
  logic sw_age_en_ff;
  logic sw_age_start_ff;
  logic hw_age_en_ff;
  logic [N_PORTS-1:0] port_mode_ff;
  logic [IDX_W-1:0] word_idx;
  logic acc_sel;
  logic idx_mapped;
  logic access;
  logic finish;
  logic wr_ok;
  logic [DATA_W-1:0] nxt_rdata;

  aging_if #(.HASH_W($clog2(BUCKET_N)), .CAM_W($clog2(CAM_N))) ag ();

  assign acc_sel = apb_paddr[ACC_BIT];
  assign word_idx = apb_paddr[ACC_BIT-1:WORD_LSB];
  assign idx_mapped = acc_sel || (word_idx <= REG_AGE_STAT);
  assign access = apb_psel && apb_penable;
  // the core counts its own access time; stalls push completion toward the timeout
  assign finish = (cfg_state_ff == CFG_WAIT) && !cfg_stall && (work_cnt_ff == ACCESS_LAST);
  assign wr_ok = finish && apb_pwrite && idx_mapped;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_state_ff <= CFG_IDLE;
      wait_cnt_ff <= '0;
      work_cnt_ff <= '0;
      apb_pready <= 1'b0;
      apb_pslverr <= 1'b0;
      apb_prdata <= '0;
    end
    else
    begin
      apb_pready <= 1'b0;
      apb_pslverr <= 1'b0;
      unique case (cfg_state_ff)
        CFG_IDLE:
        begin
          if (access)
          begin
            cfg_state_ff <= CFG_WAIT;
            wait_cnt_ff <= '0;
            work_cnt_ff <= '0;
          end
        end
        CFG_WAIT:
        begin
          wait_cnt_ff <= wait_cnt_ff + 1'b1;
          if (!cfg_stall)
          begin
            work_cnt_ff <= work_cnt_ff + 1'b1;
          end
          if (finish)
          begin
            cfg_state_ff <= CFG_DONE;
            apb_pready <= 1'b1;
            apb_pslverr <= !idx_mapped;
            apb_prdata <= (apb_pwrite || !idx_mapped) ? '0 : nxt_rdata;
          end
          else if (wait_cnt_ff == TIMEOUT_LAST)
          begin
            cfg_state_ff <= CFG_DONE;
            apb_pready <= 1'b1;
            apb_pslverr <= 1'b1;
            apb_prdata <= '0;
          end
        end
        CFG_DONE:
        begin
          // one idle cycle lets the master drop penable before a new access
          cfg_state_ff <= CFG_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    nxt_rdata = '0;
    if (acc_sel)
    begin
      nxt_rdata = acc_ff;
    end
    else
    begin
      unique case (word_idx)
        REG_LDF_WM: nxt_rdata[LVL_W-1:0] = wm_ff[0];
        REG_ADF_WM: nxt_rdata[LVL_W-1:0] = wm_ff[1];
        REG_HDF_WM: nxt_rdata[LVL_W-1:0] = wm_ff[2];
        REG_AGE_CTRL:
        begin
          nxt_rdata[AGE_SW_EN_BIT] = sw_age_en_ff;
          nxt_rdata[AGE_SW_START_BIT] = sw_age_start_ff;
          nxt_rdata[AGE_HW_EN_BIT] = hw_age_en_ff;
        end
        REG_PAUSE_MODE: nxt_rdata[N_PORTS-1:0] = port_mode_ff;
        REG_AGE_STAT: nxt_rdata[1:0] = {ag.cam_busy, ag.hash_busy};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_ff <= '0;
      wm_ff <= {NUM_FIFOS{WM_RST}};
      sw_age_en_ff <= AGE_SW_EN_RST;
      hw_age_en_ff <= AGE_HW_EN_RST;
      port_mode_ff <= '0;
    end
    else if (wr_ok)
    begin
      if (acc_sel)
      begin
        acc_ff <= apb_pwdata;
      end
      else
      begin
        unique case (word_idx)
          REG_LDF_WM: wm_ff[0] <= apb_pwdata[LVL_W-1:0];
          REG_ADF_WM: wm_ff[1] <= apb_pwdata[LVL_W-1:0];
          REG_HDF_WM: wm_ff[2] <= apb_pwdata[LVL_W-1:0];
          REG_AGE_CTRL:
          begin
            sw_age_en_ff <= apb_pwdata[AGE_SW_EN_BIT];
            hw_age_en_ff <= apb_pwdata[AGE_HW_EN_BIT];
          end
          REG_PAUSE_MODE: port_mode_ff <= apb_pwdata[N_PORTS-1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // aging trigger
  // ****************************************************************
  logic [PW-1:0] period_cnt_ff;
  logic age_tick_ff;
  logic age_idle;
  logic sw_go;
  logic hw_go;
  logic sw_start_wr;

  assign age_idle = !ag.hash_busy && !ag.cam_busy && !ag.start;
  assign sw_go = sw_age_en_ff && sw_age_start_ff && age_idle;
  assign hw_go = !sw_age_en_ff && hw_age_en_ff && age_tick_ff && age_idle;
  assign sw_start_wr = wr_ok && !acc_sel && (word_idx == REG_AGE_CTRL) &&
    apb_pwdata[AGE_SW_START_BIT];

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      period_cnt_ff <= '0;
      age_tick_ff <= 1'b0;
    end
    else
    begin
      age_tick_ff <= (period_cnt_ff == PERIOD_LAST);
      period_cnt_ff <= (period_cnt_ff == PERIOD_LAST) ? '0 : period_cnt_ff + 1'b1;
    end
  end

  // a software write that lands with the launch keeps the latch set
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sw_age_start_ff <= 1'b0;
    end
    else if (sw_start_wr)
    begin
      sw_age_start_ff <= 1'b1;
    end
    else if (sw_go)
    begin
      sw_age_start_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ag.start <= 1'b0;
    end
    else
    begin
      ag.start <= sw_go || hw_go;
    end
  end

  aging_walker #(.BUCKET_N(BUCKET_N), .CAM_N(CAM_N)) u_walker (
    .core_clk(core_clk),
    .resetn(resetn),
    .ag(ag)
  );

  assign age_hash_idx = ag.hash_idx;
  assign age_cam_idx = ag.cam_idx;

  // ****************************************************************
  // interrupt vector
  // ****************************************************************
  // pulses only: nothing is held, a receiver that misses an edge loses the event
  logic [IRQ_W-1:0] nxt_irq;

  always_comb
  begin
    nxt_irq = '0;
    for (int k = 0; k < NUM_FIFOS; k++)
    begin
      nxt_irq[2*k] = fifo_push[k] && (fifo_level[k] >= wm_ff[k]);
      nxt_irq[2*k+1] = fifo_push[k] && ({1'b0, fifo_level[k]} >= FULL_LVL);
    end
    nxt_irq[IRQ_HASH_AGE] = ag.hash_done;
    nxt_irq[IRQ_CAM_AGE] = ag.cam_done;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      interrupts <= '0;
    end
    else
    begin
      interrupts <= nxt_irq;
    end
  end

  // ****************************************************************
  // pause status and external pause
  // ****************************************************************
  for (genvar p = 0; p < N_PORTS; p++)
  begin : g_port
    always_ff @(posedge core_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        pfc_status[p] <= PAUSE_NONE;
        sched_start_grant[p] <= 1'b0;
      end
      else
      begin
        if (port_mode_ff[p])
        begin
          pfc_status[p] <= rm_port_paused[p] ? PAUSE_ALL : PAUSE_NONE;
        end
        else
        begin
          pfc_status[p] <= rm_pfc_pause[p];
        end
        // only packet starts are gated; a packet in flight never asks again
        sched_start_grant[p] <= sched_start_req[p] &&
          !ext_pause[p][sched_start_pri[p]];
      end
    end
  end

  // ****************************************************************
  // debug read
  // ****************************************************************
  logic [DBG_SEL_W-1:0] dbg_sel_ff;
  logic [DATA_W-1:0] nxt_dbg;

  always_comb
  begin
    nxt_dbg = {{(DATA_W - DBG_SEL_W){1'b0}}, dbg_sel_ff};
    for (int p = 0; p < DBG_PORTS; p++)
    begin
      if (dbg_sel_ff == DBG_SEL_W'(DBG_PORTS - p))
      begin
        nxt_dbg = '0;
        if (p < DBG_WIDE_PORTS)
        begin
          nxt_dbg[7:0] = {dbg_tx_valid_bytes[p], dbg_tx_halt[p], dbg_tx_last[p],
            dbg_tx_first[p]};
        end
        else
        begin
          nxt_dbg[5:0] = {dbg_tx_valid_bytes[p][2:0], dbg_tx_halt[p], dbg_tx_last[p],
            dbg_tx_first[p]};
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dbg_sel_ff <= '0;
      debug_read_data <= '0;
    end
    else
    begin
      dbg_sel_ff <= debug_read_select;
      debug_read_data <= nxt_dbg;
    end
  end

endmodule : switch_sideband

// file: tb/switch_sideband_properties.sv
// switch_sideband_properties: concurrent checks on the side-band top ports
// assumes: one core clock domain, asynchronous active-low reset
module switch_sideband_properties
  import sideband_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic apb_psel,
  input wire logic apb_penable,
  input wire logic apb_pready,
  input wire logic apb_pslverr,
  input wire logic [NUM_FIFOS-1:0] fifo_push,
  input wire logic [NUM_FIFOS-1:0][LVL_W-1:0] fifo_level,
  input wire logic [IRQ_W-1:0] interrupts,
  input wire logic [N_PORTS-1:0][PRI_N-1:0] ext_pause,
  input wire logic [N_PORTS-1:0] sched_start_req,
  input wire logic [N_PORTS-1:0][2:0] sched_start_pri,
  input wire logic [N_PORTS-1:0] sched_start_grant,
  input wire logic [DBG_SEL_W-1:0] debug_read_select,
  input wire logic [DATA_W-1:0] debug_read_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // covers the longest build timeout
  localparam int WAIT_MAX = 300;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ****
  // sequences
  // ****
  sequence access_taken;
    $rose(apb_penable) && apb_psel;
  endsequence

  sequence sel_steady;
    (debug_read_select > 9'h00C) ##1 $stable(debug_read_select) ##1 $stable(debug_read_select);
  endsequence

  // ****
  // properties
  // ****
  chk_ready_bound: assert property (access_taken |-> ##[3:WAIT_MAX] apb_pready)
    else $error("access not ended in time");
  chk_ready_pulse: assert property (apb_pready |=> !apb_pready)
    else $error("ready longer than one cycle");
  chk_ready_access: assert property (apb_pready |-> apb_psel && apb_penable)
    else $error("ready outside access");
  chk_err_ready: assert property (apb_pslverr |-> apb_pready)
    else $error("error without ready");
  chk_irq_reserved: assert property (interrupts[IRQ_W-1:8] == '0)
    else $error("reserved interrupt bit high");
  chk_full_raise: assert property (fifo_push[0] && fifo_level[0] >= DEPTH
    |=> interrupts[1])
    else $error("full push not flagged");
  chk_full_cause: assert property (interrupts[3] |->
    $past(fifo_push[1]) && $past(fifo_level[1]) >= DEPTH)
    else $error("full flag without cause");
  chk_hash_pulse: assert property (interrupts[IRQ_HASH_AGE] |=> !interrupts[IRQ_HASH_AGE])
    else $error("aging flag not a pulse");
  chk_debug_const: assert property (sel_steady |=>
    debug_read_data == DATA_W'($past(debug_read_select)))
    else $error("unmapped select data wrong");
  for (genvar p = 0; p < N_PORTS; p++)
  begin : g_port
    chk_xoff_hold: assert property (sched_start_req[p] &&
      ext_pause[p][sched_start_pri[p]] |=> !sched_start_grant[p])
      else $error("start granted under xoff");
    chk_xon_grant: assert property (sched_start_req[p] &&
      !ext_pause[p][sched_start_pri[p]] |=> sched_start_grant[p])
      else $error("start refused under xon");
  end
endmodule : switch_sideband_properties

bind switch_sideband switch_sideband_properties #(.DEPTH(DEPTH)) switch_sideband_properties_inst (.*);

// file: tb/cfg_master_model.sv
// cfg_master_model: cpu side of the configuration bus, one transfer per call
// assumes: caller enters between edges; transfers are whole words
module cfg_master_model
  import sideband_pkg::*;
(
  input wire logic core_clk,
  output logic [ADDR_W-1:0] apb_paddr,
  output logic apb_psel,
  output logic apb_penable,
  output logic apb_pwrite,
  output logic [DATA_W-1:0] apb_pwdata,
  input wire logic apb_pready,
  input wire logic [DATA_W-1:0] apb_prdata,
  input wire logic apb_pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    apb_psel = 1'b0;
    apb_penable = 1'b0;
    apb_pwrite = 1'b0;
    apb_paddr = '0;
    apb_pwdata = '0;
  end

  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                      output logic [DATA_W-1:0] rd, output logic err);
    int n;
    @(posedge core_clk);
    apb_psel <= 1'b1;
    apb_pwrite <= wr;
    apb_paddr <= a;
    apb_pwdata <= wd;
    @(posedge core_clk);
    apb_penable <= 1'b1;
    n = 0;
    // latency varies, so wait on ready rather than count states
    do @(posedge core_clk); while (apb_pready !== 1'b1 && ++n < 400);
    rd = apb_prdata;
    err = apb_pslverr;
    apb_psel <= 1'b0;
    apb_penable <= 1'b0;
    // released lines must not keep showing the last value
    apb_paddr <= ~a;
    apb_pwdata <= ~wd;
  endtask : xfer
endmodule : cfg_master_model

// file: tb/tb.sv
// tb: self-checking bench for the switch side-band block
// assumes: short aging period, timeout and bucket size for simulation
module tb
  import sideband_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BKT = 8;
  logic core_clk, resetn, cfg_stall, apb_psel, apb_penable, apb_pwrite, apb_pready, apb_pslverr;
  logic err, seen_hash_end, seen_cam_end;
  logic [ADDR_W-1:0] apb_paddr;
  logic [DATA_W-1:0] apb_pwdata, apb_prdata, debug_read_data, rd;
  logic [NUM_FIFOS-1:0] fifo_push;
  logic [NUM_FIFOS-1:0][LVL_W-1:0] fifo_level;
  logic [IRQ_W-1:0] interrupts;
  logic [2:0] age_hash_idx;
  logic [4:0] age_cam_idx;
  logic [N_PORTS-1:0] rm_port_paused, sched_start_req, sched_start_grant;
  logic [N_PORTS-1:0][PRI_N-1:0] rm_pfc_pause, pfc_status, ext_pause;
  logic [N_PORTS-1:0][2:0] sched_start_pri;
  logic [DBG_SEL_W-1:0] debug_read_select;
  logic [DBG_PORTS-1:0][4:0] dbg_tx_valid_bytes;
  logic [DBG_PORTS-1:0] dbg_tx_halt, dbg_tx_last, dbg_tx_first;
  int fail_count, checks;

  switch_sideband #(.AGE_PERIOD_CYC(64), .TIMEOUT_CYC(16), .BUCKET_N(BKT))
    switch_sideband_inst (.*);
  cfg_master_model cfg_master_model_inst (.*);

  // ****
  // shared tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cfg(input logic wr, input logic [27:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    cfg_master_model_inst.xfer(wr, a, d, rd, err);
    chk("prdata", ed, rd);
    chk("pslverr", 32'(ee), 32'(err));
  endtask : cfg

  task automatic irq_try(input int k, input logic [9:0] lvl, input logic [31:0] e);
    @(posedge core_clk);
    fifo_push[k] <= 1'b1;
    fifo_level[k] <= lvl;
    @(posedge core_clk);
    fifo_push[k] <= 1'b0;
    #1 chk("irq", e, interrupts & 32'hFFFFFF3F);
    @(posedge core_clk);
    #1 chk("irq gone", 0, interrupts & 32'hFFFFFF3F);
  endtask : irq_try

  task automatic wait_irq(input int b, input int lim);
    int n;
    n = 0;
    while (interrupts[b] !== 1'b1 && n++ < lim)
    begin
      @(posedge core_clk);
      #1;
      if (age_hash_idx === 3'(BKT - 1)) seen_hash_end = 1'b1;
      if (age_cam_idx === 5'h1F) seen_cam_end = 1'b1;
    end
    chk("aging irq", 1, 32'(interrupts[b]));
    @(posedge core_clk);
    #1 chk("aging pulse", 0, 32'(interrupts[b]));
  endtask : wait_irq

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // ****
  // scenarios
  // ****
  task automatic t_regs();
    cfg(0, {1'b0, REG_HDF_WM, 2'h0}, 0, 32'h180, 0);
    cfg(1, {1'b0, REG_LDF_WM, 2'h3}, 32'h55, 0, 0);
    cfg(0, {1'b0, REG_LDF_WM, 2'h1}, 0, 32'h55, 0);
    cfg(1, {1'b0, REG_LDF_WM, 2'h0}, 32'h180, 0, 0);
    cfg(0, {1'b0, 25'h6, 2'h0}, 0, 0, 1);
    cfg(1, {1'b0, 25'h6, 2'h2}, 32'h1, 0, 1);
    cfg(1, {1'b1, 25'h6, 2'h0}, 32'hCAFE_0001, 0, 0);
    cfg(0, {1'b1, 25'h2, 2'h1}, 0, 32'hCAFE_0001, 0);
    cfg(0, {1'b0, REG_AGE_CTRL, 2'h0}, 0, 32'h4, 0);
  endtask : t_regs

  task automatic t_timeout();
    @(posedge core_clk);
    cfg_stall <= 1'b1;
    cfg(0, {1'b0, REG_LDF_WM, 2'h0}, 0, 0, 1);
    cfg_stall <= 1'b0;
  endtask : t_timeout

  task automatic t_irq();
    for (int k = 0; k < NUM_FIFOS; k++)
    begin
      irq_try(k, 10'h17F, 0);
      irq_try(k, 10'h180, 32'h1 << (2 * k));
      irq_try(k, 10'h200, 32'h3 << (2 * k));
    end
  endtask : t_irq

  task automatic t_pause();
    cfg(1, {1'b0, REG_PAUSE_MODE, 2'h0}, 32'h1, 0, 0);
    @(posedge core_clk);
    rm_port_paused <= 11'h001;
    rm_pfc_pause <= {N_PORTS{8'h5A}};
    ext_pause[3] <= 8'h10;
    sched_start_req <= 11'h018;
    sched_start_pri[3] <= 3'h4;
    sched_start_pri[4] <= 3'h4;
    repeat (2) @(posedge core_clk);
    #1 chk("pfc port mode", PAUSE_ALL, pfc_status[0]);
    chk("pfc prio mode", 8'h5A, pfc_status[1]);
    chk("grant", 32'h10, sched_start_grant);
    @(posedge core_clk);
    rm_port_paused <= '0;
    sched_start_pri[3] <= 3'h3;
    repeat (2) @(posedge core_clk);
    #1 chk("pfc port mode", PAUSE_NONE, pfc_status[0]);
    chk("grant", 32'h18, sched_start_grant);
    sched_start_req <= '0;
  endtask : t_pause

  task automatic t_debug();
    int p;
    logic [31:0] e;
    @(posedge core_clk);
    for (int i = 0; i < DBG_PORTS; i++) dbg_tx_valid_bytes[i] <= 5'(i * 3 + 5);
    dbg_tx_halt <= 12'hA5C;
    dbg_tx_last <= 12'h3C6;
    dbg_tx_first <= 12'h96F;
    for (int s = 0; s < 15; s++)
    begin
      @(posedge core_clk);
      debug_read_select <= (s == 14) ? 9'h1FF : 9'(s);
      repeat (3) @(posedge core_clk);
      p = 12 - s;
      e = (s == 14) ? 32'h1FF : 32'(s);
      if (s >= 1 && s <= 12)
        e = p < 2 ? {24'h0, dbg_tx_valid_bytes[p], dbg_tx_halt[p], dbg_tx_last[p], dbg_tx_first[p]}
          : {26'h0, dbg_tx_valid_bytes[p][2:0], dbg_tx_halt[p], dbg_tx_last[p], dbg_tx_first[p]};
      #1 chk("debug data", e, debug_read_data);
    end
  endtask : t_debug

  task automatic t_aging();
    int n;
    wait_irq(IRQ_HASH_AGE, 200);
    cfg(1, {1'b0, REG_AGE_CTRL, 2'h0}, 32'h1, 0, 0);
    // let a running walk finish
    repeat (60) @(posedge core_clk);
    n = 0;
    repeat (150)
    begin
      @(posedge core_clk);
      #1 if (interrupts[7:6] !== 2'h0) n++;
    end
    chk("silent aging", 0, 32'(n));
    seen_hash_end = 1'b0;
    seen_cam_end = 1'b0;
    cfg(1, {1'b0, REG_AGE_CTRL, 2'h0}, 32'h3, 0, 0);
    wait_irq(IRQ_HASH_AGE, BKT + 8);
    chk("bucket end", 1, 32'(seen_hash_end));
    wait_irq(IRQ_CAM_AGE, CAM_ENTRIES + 8);
    chk("cam end", 1, 32'(seen_cam_end));
  endtask : t_aging

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end

  initial
  begin
    {resetn, cfg_stall, fifo_push, fifo_level, rm_port_paused, rm_pfc_pause} = '0;
    {ext_pause, sched_start_req, sched_start_pri, debug_read_select} = '0;
    {dbg_tx_valid_bytes, dbg_tx_halt, dbg_tx_last, dbg_tx_first} = '0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_timeout();
    t_irq();
    t_pause();
    t_debug();
    t_aging();
    stop_test();
  end
endmodule : tb
